// File: sem_consts.svh
`ifndef SEM_CONSTS_SVH
`define SEM_CONSTS_SVH
// Register byte addresses
`define ADDR_EXT_CONFIG_CONTROL   12'h0000
`define ADDR_FW_SEMAPHORE_REG     12'h0004
`define ADDR_FEATURE_EXT_CONFIG   12'h0008
`define ADDR_STATUS               12'h000C
// Field positions in ext_config_control
`define BIT_HW_WAIT_WDOG_ENABLE   3
`define BIT_SW_FLAG               5
`define BIT_HW_PHY_OWNER          6
// Field positions in fw_semaphore_register
`define BIT_FW_FLAG               0
`define BIT_SW_PHY_RESET_PERMIT   1
`define BIT_SW_PHY_INIT_PERMIT    2
// Field position in feature_ext_config
`define BIT_FEATURE_WDOG_ENABLE   10
// Field positions in status
`define BIT_STAT_HW_WAIT          0
`define BIT_STAT_SW_PEND          1
`define BIT_STAT_FW_PEND          2
`define BIT_STAT_RR_FW            3
// Watchdog timing
`define WDOG_TIME_MS              100
`define CLOCK_MHZ                 100
`define WDOG_CYCLES               (`WDOG_TIME_MS * 1000 * `CLOCK_MHZ)
`define WDOG_WIDTH                24
`define ZERO32                    32'h0000_0000
`endif

// File: sem_pkg.sv
package sem_pkg;
  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_HW   = 2'b01,
    OWN_SW   = 2'b10,
    OWN_FW   = 2'b11
  } owner_type;

  typedef struct packed {
    logic sw_req;
    logic fw_req;
    logic hw_req;
  } request_type;

  typedef enum logic [1:0] {
    HW_IDLE = 2'b00,
    HW_WAIT = 2'b01,
    HW_BUSY = 2'b10
  } hw_state_type;
endpackage

// File: wait_watchdog.sv
`timescale 1ns/1ps
`include "sem_consts.svh"
module wait_watchdog #(
  parameter int unsigned LIMIT = `WDOG_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic run,
  output logic      expired
);
  logic [`WDOG_WIDTH-1:0] count_reg;

  // Counter idles at zero whenever not waiting
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (!run) begin
      count_reg <= '0;
    end else if (count_reg < LIMIT[`WDOG_WIDTH-1:0]) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Fires once the wait has run past the limit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= run && (count_reg >= LIMIT[`WDOG_WIDTH-1:0]);
    end
  end
endmodule // wait_watchdog

// File: shared_resource_semaphore.sv
// Functional notes
// [RULE1] Hardware engine requests ownership, waits for grant before PHY access.
// [RULE2] Hardware grant only while software and firmware flags are clear.
// [RULE3] Hardware ownership clears as soon as its PHY accesses finish.
// [RULE4] Early variant: enabled watchdog ignores other flags after 100 ms wait.
// [RULE5] Later variant: feature bit 10 watchdog clears other flags after 100 ms.
// [RULE6] After hardware finishes, pending requests get granted, one owner only.
// [RULE7] Software flag reads set only when hardware and firmware flags clear.
// [RULE8] Software waits for grant before shared writes, clears when done.
// [RULE9] Firmware flag granted only when hardware and software flags clear.
// [RULE10] Firmware clears reset permit, may set init permit, clears flag when done.
// [RULE11] Arbitration happens only while nobody holds ownership.
// [RULE12] Hardware engine always wins simultaneous requests.
// [RULE13] Software and firmware alternate round-robin on simultaneous requests.
// [RULE14] Flags are advisory; register writes are never blocked by them.
// [RULE15] Firmware may watch for violations and reset the device.
// [RULE16] Software watches hardware and firmware flags for status.
// [RULE17] Clients take the semaphore before writing shared control registers.
// [RULE18] Reset clears all flags, idles watchdog, pointer starts at software.
`timescale 1ns/1ps
`include "sem_consts.svh"
module shared_resource_semaphore #(
  parameter int unsigned WDOG_CYCLES = `WDOG_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_claim,
  input  wire logic        hw_done,
  output logic             hw_phy_grant,
  output logic             sw_owns,
  output logic             fw_owns
);
  logic                  hw_phy_owner_flag;
  logic                  sw_request_grant_flag;
  logic                  fw_request_grant_flag;
  logic                  sw_req_reg;
  logic                  fw_req_reg;
  logic                  hw_wait_watchdog_enable;
  logic                  wdog_feature_enable;
  logic                  sw_phy_reset_permit;
  logic                  sw_phy_init_permit;
  logic                  rr_fw_next_reg;
  logic                  wd_expired;
  logic                  wd_run;
  logic                  bus_write;
  logic                  bus_read;
  logic                  addr_ok;
  logic [31:0]           rdata_next;
  sem_pkg::hw_state_type hw_state_reg;
  sem_pkg::request_type  req;
  logic                  none_owned;
  logic                  grant_hw;
  logic                  grant_sw;
  logic                  grant_fw;
  logic                  wd_force;

  // Zero-wait APB: access phase completes in its first cycle
  assign bus_write = psel && penable && pwrite;
  assign bus_read  = psel && penable && !pwrite;
  assign addr_ok = (paddr == `ADDR_EXT_CONFIG_CONTROL) || (paddr == `ADDR_FW_SEMAPHORE_REG) ||
                   (paddr == `ADDR_FEATURE_EXT_CONFIG) || (paddr == `ADDR_STATUS);

  assign req.hw_req = (hw_state_reg == sem_pkg::HW_WAIT);
  assign req.sw_req = sw_req_reg;
  assign req.fw_req = fw_req_reg;
  assign none_owned = !hw_phy_owner_flag && !sw_request_grant_flag && !fw_request_grant_flag;
  assign wd_run = req.hw_req && (hw_wait_watchdog_enable || wdog_feature_enable);
  // Watchdog overrides the held flags for the hardware engine
  assign wd_force = wd_expired && req.hw_req; // [RULE4] [RULE5]

  // Grant only while idle; hardware first, then round-robin
  always_comb begin
    grant_hw = 1'b0;
    grant_sw = 1'b0;
    grant_fw = 1'b0;
    if (none_owned) begin // [RULE11]
      if (req.hw_req) begin
        grant_hw = 1'b1; // [RULE12] [RULE2]
      end else if (req.sw_req && req.fw_req) begin
        grant_fw = rr_fw_next_reg; // [RULE13]
        grant_sw = !rr_fw_next_reg;
      end else if (req.sw_req) begin
        grant_sw = 1'b1; // [RULE7]
      end else if (req.fw_req) begin
        grant_fw = 1'b1; // [RULE9]
      end
    end
  end

  wait_watchdog #(
    .LIMIT (WDOG_CYCLES)
  ) u_wait_watchdog (
    .clock   (clock),
    .rst     (rst),
    .run     (wd_run),
    .expired (wd_expired)
  );

  // Hardware engine sequencing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hw_state_reg <= sem_pkg::HW_IDLE; // [RULE18]
    end else begin
      case (hw_state_reg)
        sem_pkg::HW_IDLE: begin
          if (hw_claim) begin
            hw_state_reg <= sem_pkg::HW_WAIT; // [RULE1]
          end
        end
        sem_pkg::HW_WAIT: begin
          if (grant_hw || wd_force) begin
            hw_state_reg <= sem_pkg::HW_BUSY;
          end
        end
        sem_pkg::HW_BUSY: begin
          if (hw_done) begin
            hw_state_reg <= sem_pkg::HW_IDLE; // [RULE3]
          end
        end
        default: begin
          hw_state_reg <= sem_pkg::HW_IDLE;
        end
      endcase
    end
  end

  // Hardware ownership flag follows the engine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hw_phy_owner_flag <= 1'b0;
    end else if (hw_state_reg == sem_pkg::HW_BUSY && hw_done) begin
      hw_phy_owner_flag <= 1'b0; // [RULE3]
    end else if (grant_hw || wd_force) begin
      hw_phy_owner_flag <= 1'b1; // [RULE1]
    end
  end

  // Software request and grant; software write of zero releases
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sw_req_reg            <= 1'b0;
      sw_request_grant_flag <= 1'b0;
    end else if (wd_force && wdog_feature_enable) begin
      sw_req_reg            <= 1'b0; // [RULE5]
      sw_request_grant_flag <= 1'b0;
    end else if (bus_write && paddr == `ADDR_EXT_CONFIG_CONTROL) begin
      sw_req_reg            <= pwdata[`BIT_SW_FLAG];
      sw_request_grant_flag <= sw_request_grant_flag && pwdata[`BIT_SW_FLAG];
    end else if (grant_sw) begin
      sw_request_grant_flag <= 1'b1; // [RULE6] [RULE7]
    end
  end

  // Firmware request and grant
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fw_req_reg            <= 1'b0;
      fw_request_grant_flag <= 1'b0;
    end else if (wd_force && wdog_feature_enable) begin
      fw_req_reg            <= 1'b0; // [RULE5]
      fw_request_grant_flag <= 1'b0;
    end else if (bus_write && paddr == `ADDR_FW_SEMAPHORE_REG) begin
      fw_req_reg            <= pwdata[`BIT_FW_FLAG];
      fw_request_grant_flag <= fw_request_grant_flag && pwdata[`BIT_FW_FLAG];
    end else if (grant_fw) begin
      fw_request_grant_flag <= 1'b1; // [RULE6] [RULE9]
    end
  end

  // Round-robin pointer moves away from the winner after each software or firmware grant
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rr_fw_next_reg <= 1'b0; // [RULE18]
    end else if (grant_sw || grant_fw) begin
      rr_fw_next_reg <= grant_sw; // [RULE13]
    end
  end

  // Plain control bits; never gated by the flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hw_wait_watchdog_enable <= 1'b0;
      wdog_feature_enable     <= 1'b0;
      sw_phy_reset_permit     <= 1'b0;
      sw_phy_init_permit      <= 1'b0;
    end else if (bus_write) begin // [RULE14]
      if (paddr == `ADDR_EXT_CONFIG_CONTROL) begin
        hw_wait_watchdog_enable <= pwdata[`BIT_HW_WAIT_WDOG_ENABLE];
      end else if (paddr == `ADDR_FW_SEMAPHORE_REG) begin
        sw_phy_reset_permit <= pwdata[`BIT_SW_PHY_RESET_PERMIT];
        sw_phy_init_permit  <= pwdata[`BIT_SW_PHY_INIT_PERMIT];
      end else if (paddr == `ADDR_FEATURE_EXT_CONFIG) begin
        wdog_feature_enable <= pwdata[`BIT_FEATURE_WDOG_ENABLE];
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_next = `ZERO32;
    if (paddr == `ADDR_EXT_CONFIG_CONTROL) begin
      rdata_next[`BIT_HW_WAIT_WDOG_ENABLE] = hw_wait_watchdog_enable;
      rdata_next[`BIT_SW_FLAG]             = sw_request_grant_flag;
      rdata_next[`BIT_HW_PHY_OWNER]        = hw_phy_owner_flag;
    end else if (paddr == `ADDR_FW_SEMAPHORE_REG) begin
      rdata_next[`BIT_FW_FLAG]             = fw_request_grant_flag;
      rdata_next[`BIT_SW_PHY_RESET_PERMIT] = sw_phy_reset_permit;
      rdata_next[`BIT_SW_PHY_INIT_PERMIT]  = sw_phy_init_permit;
    end else if (paddr == `ADDR_FEATURE_EXT_CONFIG) begin
      rdata_next[`BIT_FEATURE_WDOG_ENABLE] = wdog_feature_enable;
    end else if (paddr == `ADDR_STATUS) begin
      // Software and firmware request bits stay set while granted; the hardware bit drops on grant
      rdata_next[`BIT_STAT_HW_WAIT] = req.hw_req;
      rdata_next[`BIT_STAT_SW_PEND] = sw_req_reg;
      rdata_next[`BIT_STAT_FW_PEND] = fw_req_reg;
      rdata_next[`BIT_STAT_RR_FW]   = rr_fw_next_reg;
    end
  end

  // Registered bus answers, one cycle per access phase
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= `ZERO32;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      prdata  <= (psel && !penable && !pwrite) ? rdata_next : `ZERO32;
    end
  end

  // Owner outputs for the engine and status pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hw_phy_grant <= 1'b0;
      sw_owns      <= 1'b0;
      fw_owns      <= 1'b0;
    end else begin
      hw_phy_grant <= hw_phy_owner_flag && hw_state_reg == sem_pkg::HW_BUSY && !hw_done; // [RULE1]
      sw_owns      <= sw_request_grant_flag;
      fw_owns      <= fw_request_grant_flag;
    end
  end

  sequence s_hw_waits;
    req.hw_req && !sw_request_grant_flag && !fw_request_grant_flag && !hw_phy_owner_flag;
  endsequence

  AST_HW_GRANT_WHEN_CLEAR: assert property (@(posedge clock) disable iff (rst) // [RULE2]
    s_hw_waits |=> hw_phy_owner_flag)
    else $error("hardware not granted while clear");
  AST_HW_NEEDS_CLEAR: assert property (@(posedge clock) disable iff (rst) // [RULE2]
    $rose(hw_phy_owner_flag) |-> $past(!sw_request_grant_flag && !fw_request_grant_flag) || $past(wd_force))
    else $error("hardware granted while others own");
  AST_ONE_OWNER: assert property (@(posedge clock) disable iff (rst) // [RULE6]
    !(sw_request_grant_flag && fw_request_grant_flag) && !(hw_phy_owner_flag && (sw_request_grant_flag ||
      fw_request_grant_flag) && !wd_force && !hw_wait_watchdog_enable))
    else $error("more than one owner");
  AST_SW_GRANT_CLEAR: assert property (@(posedge clock) disable iff (rst) // [RULE7]
    $rose(sw_request_grant_flag) |-> $past(!hw_phy_owner_flag && !fw_request_grant_flag))
    else $error("software granted while busy");
  AST_FW_GRANT_CLEAR: assert property (@(posedge clock) disable iff (rst) // [RULE9]
    $rose(fw_request_grant_flag) |-> $past(!hw_phy_owner_flag && !sw_request_grant_flag))
    else $error("firmware granted while busy");
  AST_HW_PRIORITY: assert property (@(posedge clock) disable iff (rst) // [RULE12]
    (none_owned && req.hw_req && (req.sw_req || req.fw_req)) |=> hw_phy_owner_flag && !sw_request_grant_flag
      && !fw_request_grant_flag)
    else $error("hardware lost priority");
  AST_RR_ALTERNATE: assert property (@(posedge clock) disable iff (rst) // [RULE13]
    grant_sw |=> rr_fw_next_reg)
    else $error("round robin did not advance");
  AST_HW_RELEASE: assert property (@(posedge clock) disable iff (rst) // [RULE3]
    (hw_state_reg == sem_pkg::HW_BUSY && hw_done) |=> !hw_phy_owner_flag ##1 !hw_phy_grant)
    else $error("hardware ownership not released");
  AST_WDOG_CLEARS: assert property (@(posedge clock) disable iff (rst) // [RULE5]
    (wd_force && wdog_feature_enable) |=> !sw_request_grant_flag && !fw_request_grant_flag && hw_phy_owner_flag)
    else $error("watchdog did not clear flags");
  AST_ARB_ONLY_IDLE: assert property (@(posedge clock) disable iff (rst) // [RULE11]
    (sw_request_grant_flag && req.fw_req) |=> !fw_request_grant_flag)
    else $error("arbitration while owned");

  sequence s_hw_owned;
    hw_phy_owner_flag && hw_state_reg == sem_pkg::HW_BUSY && !hw_done;
  endsequence
  sequence s_sw_alone;
    none_owned && !req.hw_req && req.sw_req && !req.fw_req && !bus_write;
  endsequence

  AST_HW_PIN_FOLLOWS: assert property (@(posedge clock) disable iff (rst) // [RULE1]
    s_hw_owned |=> hw_phy_grant)
    else $error("engine grant pin missing");
  AST_HW_PIN_DROPS: assert property (@(posedge clock) disable iff (rst) // [RULE3]
    !hw_phy_owner_flag |=> !hw_phy_grant)
    else $error("engine grant pin without ownership");
  AST_SW_GRANT_IDLE: assert property (@(posedge clock) disable iff (rst) // [RULE7]
    s_sw_alone |=> sw_request_grant_flag)
    else $error("software not granted while idle");
  AST_RR_TO_SW: assert property (@(posedge clock) disable iff (rst) // [RULE13]
    grant_fw |=> !rr_fw_next_reg)
    else $error("round robin did not return");
  AST_WDOG_IGNORES: assert property (@(posedge clock) disable iff (rst) // [RULE4]
    (wd_force && !wdog_feature_enable) |=> hw_phy_owner_flag)
    else $error("watchdog did not take ownership");
endmodule // shared_resource_semaphore

// File: apb_client_model.sv
`timescale 1ns/1ps
module apb_client_model (
  input  wire logic        clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // Held until pready seen at an edge; no fixed latency assumed
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Stale data inverted so it never passes for a live write
    pwdata  <= ~d;
  endtask
endmodule // apb_client_model

// File: shared_resource_semaphore_tb_top.sv
`timescale 1ns/1ps
`include "sem_consts.svh"
module shared_resource_semaphore_tb_top;
  localparam logic [31:0] SW   = 32'h0000_0001 << `BIT_SW_FLAG;
  localparam logic [31:0] HW   = 32'h0000_0001 << `BIT_HW_PHY_OWNER;
  localparam logic [31:0] WD3  = 32'h0000_0001 << `BIT_HW_WAIT_WDOG_ENABLE;
  localparam logic [31:0] FW   = 32'h0000_0001 << `BIT_FW_FLAG;
  localparam logic [31:0] RSTP = 32'h0000_0001 << `BIT_SW_PHY_RESET_PERMIT;
  localparam logic [31:0] INIP = 32'h0000_0001 << `BIT_SW_PHY_INIT_PERMIT;
  localparam logic [31:0] WD10 = 32'h0000_0001 << `BIT_FEATURE_WDOG_ENABLE;
  localparam logic [31:0] Z    = `ZERO32;
  // Short watchdog keeps the run brief
  localparam int unsigned WD = 20;
  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic        hw_claim, hw_done, hw_phy_grant, sw_owns, fw_owns, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          n_fail, total_checks;

  shared_resource_semaphore #(.WDOG_CYCLES(WD)) DUT (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hw_claim(hw_claim), .hw_done(hw_done),
    .hw_phy_grant(hw_phy_grant), .sw_owns(sw_owns), .fw_owns(fw_owns));
  apb_client_model m (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    m.xfer(a, 1'b0, Z, q, e);
    chk32(q, exp);
    chk1(e, 1'b0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    m.xfer(a, 1'b1, d, q, e);
    chk1(e, 1'b0);
  endtask
  task automatic pulse(input logic claim);
    @(posedge clock);
    if (claim) hw_claim <= 1'b1;
    else hw_done <= 1'b1;
    @(posedge clock);
    hw_claim <= 1'b0;
    hw_done  <= 1'b0;
  endtask
  // Bounded wait on the engine grant, then settle for arbitration
  task automatic wait_grant(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && hw_phy_grant !== v; i++) @(posedge clock);
    chk1(hw_phy_grant, v);
    repeat (2) @(posedge clock);
  endtask
  task summarize;
    if (n_fail == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    summarize();
  end

  initial begin
    rst = 1'b1;
    hw_claim = 1'b0;
    hw_done = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(`ADDR_EXT_CONFIG_CONTROL, Z);
    rd(`ADDR_FW_SEMAPHORE_REG, Z);
    rd(`ADDR_STATUS, Z);
    chk1(hw_phy_grant | sw_owns | fw_owns, 1'b0);
    m.xfer(12'h010, 1'b0, Z, q, e);
    chk1(e, 1'b1);
    // Engine alone, then both soft clients queue behind it
    pulse(1'b1);
    wait_grant(1'b1, 6);
    wr(`ADDR_EXT_CONFIG_CONTROL, SW);
    wr(`ADDR_FW_SEMAPHORE_REG, FW);
    rd(`ADDR_EXT_CONFIG_CONTROL, HW);
    rd(`ADDR_FW_SEMAPHORE_REG, Z);
    pulse(1'b0);
    wait_grant(1'b0, 6);
    rd(`ADDR_EXT_CONFIG_CONTROL, SW);
    rd(`ADDR_FW_SEMAPHORE_REG, Z);
    chk1(sw_owns, 1'b1);
    // Engine waits on software, then beats pending firmware
    pulse(1'b1);
    rd(`ADDR_STATUS, 32'h0000_000F);
    chk1(hw_phy_grant, 1'b0);
    wr(`ADDR_EXT_CONFIG_CONTROL, Z);
    wait_grant(1'b1, 8);
    rd(`ADDR_FW_SEMAPHORE_REG, Z);
    wr(`ADDR_EXT_CONFIG_CONTROL, SW);
    pulse(1'b0);
    wait_grant(1'b0, 6);
    rd(`ADDR_FW_SEMAPHORE_REG, FW);
    chk1(fw_owns, 1'b1);
    rd(`ADDR_EXT_CONFIG_CONTROL, Z);
    wr(`ADDR_FW_SEMAPHORE_REG, FW | INIP);
    rd(`ADDR_FW_SEMAPHORE_REG, FW | INIP);
    wr(`ADDR_FW_SEMAPHORE_REG, Z);
    rd(`ADDR_EXT_CONFIG_CONTROL, SW);
    chk1(fw_owns, 1'b0);
    // Non-owner writes still land
    wr(`ADDR_FW_SEMAPHORE_REG, RSTP);
    rd(`ADDR_FW_SEMAPHORE_REG, RSTP);
    // Watchdog that ignores the soft flags
    wr(`ADDR_EXT_CONFIG_CONTROL, SW | WD3);
    pulse(1'b1);
    repeat (WD / 2) @(posedge clock);
    chk1(hw_phy_grant, 1'b0);
    wait_grant(1'b1, WD + 10);
    rd(`ADDR_EXT_CONFIG_CONTROL, SW | WD3 | HW);
    pulse(1'b0);
    wait_grant(1'b0, 6);
    // Watchdog that clears the soft flags
    wr(`ADDR_EXT_CONFIG_CONTROL, SW);
    wr(`ADDR_FEATURE_EXT_CONFIG, WD10);
    wr(`ADDR_FW_SEMAPHORE_REG, FW);
    rd(`ADDR_FEATURE_EXT_CONFIG, WD10);
    pulse(1'b1);
    repeat (WD / 2) @(posedge clock);
    chk1(hw_phy_grant, 1'b0);
    wait_grant(1'b1, WD + 10);
    rd(`ADDR_EXT_CONFIG_CONTROL, HW);
    rd(`ADDR_FW_SEMAPHORE_REG, Z);
    pulse(1'b0);
    wait_grant(1'b0, 6);
    rd(`ADDR_EXT_CONFIG_CONTROL, Z);
    // Reset in mid-run: engine owns, software pending
    pulse(1'b1);
    wait_grant(1'b1, 6);
    wr(`ADDR_EXT_CONFIG_CONTROL, SW);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    chk1(hw_phy_grant | sw_owns, 1'b0);
    rd(`ADDR_EXT_CONFIG_CONTROL, Z);
    rd(`ADDR_FEATURE_EXT_CONFIG, Z);
    rd(`ADDR_STATUS, Z);
    summarize();
  end
endmodule // shared_resource_semaphore_tb_top
